//--- msis_pkg.sv
// Purpose: Shared constants and types for the motion sensor status block.
// Assumes: One system clock at 40 MHz and one register-read link clock.
// Notes: The identity value below is arbitrary and stands in for the factory code.
// Contract
// - Mode field bits 1:0, standby/wake/sleep.
// - Flags set on rise, held until read.
// - Source bit layout 7,5,4,3,2,0; others zero.
// - Ready flag cleared only by axis reads.
// - Ready flag from ready or overrun, enabled.
// - Auto-sleep flag on transition, cleared reading mode.
// - Wake to sleep after idle limit exceeded.
// - Sleep to wake on selected event.
// - Transient flag follows event-active and enable.
// - Orientation flag follows changed bit and enable.
// - Tap flag follows event-active and enable.
// - Fall/motion flag follows event-active and enable.
// - Read-only eight-bit identity register.
// - All source flags reset to zero.
// - All-axis ready clears after enabled reads.
// - All-axis overrun set on unread overwrite.
package msis_pkg;

	// Register offsets on the serial register map.
	localparam logic [7:0] MSIS_ADDR_SYSTEM_MODE = 8'h0b;
	localparam logic [7:0] MSIS_ADDR_INT_SOURCE  = 8'h0c;
	localparam logic [7:0] MSIS_ADDR_PART_ID     = 8'h0d;

	// Reset values; the identity value is arbitrary.
	localparam logic [7:0] MSIS_RST_SYSTEM_MODE = 8'h00;
	localparam logic [7:0] MSIS_RST_INT_SOURCE  = 8'h00;
	localparam logic [7:0] MSIS_PART_ID_VALUE   = 8'h5c;
	localparam logic [7:0] MSIS_RST_IDLE        = 8'h00;

	// Field positions in the interrupt source register.
	localparam int MSIS_BIT_ASLP  = 7;
	localparam int MSIS_BIT_TRANS = 5;
	localparam int MSIS_BIT_ORIEN = 4;
	localparam int MSIS_BIT_TAP   = 3;
	localparam int MSIS_BIT_FALL  = 2;
	localparam int MSIS_BIT_DRDY  = 0;

	// Indices of read events carried from the link to the system clock.
	localparam int MSIS_EV_MODE  = 0;
	localparam int MSIS_EV_TRANS = 1;
	localparam int MSIS_EV_ORIEN = 2;
	localparam int MSIS_EV_TAP   = 3;
	localparam int MSIS_EV_FALL  = 4;
	localparam int MSIS_EV_X     = 5;
	localparam int MSIS_EV_Y     = 6;
	localparam int MSIS_EV_Z     = 7;
	localparam int MSIS_NUM_EV   = 8;

	// Operating modes in their register encoding 00, 01, 10.
	typedef enum logic [1:0] {
		MSIS_STANDBY,
		MSIS_WAKE,
		MSIS_SLEEP
	} msis_mode_t;

	// Gray codes used to carry the mode across clocks; each step to or from wake moves one bit.
	localparam logic [1:0] MSIS_GRAY_STANDBY = 2'h0;
	localparam logic [1:0] MSIS_GRAY_WAKE    = 2'h1;
	localparam logic [1:0] MSIS_GRAY_SLEEP   = 2'h3;

	// One bit per detection function.
	typedef struct packed {
		logic transient;
		logic orientation;
		logic tap;
		logic fall_motion;
	} msis_func_t;

	// Read strobes of the source and data registers kept outside.
	typedef struct packed {
		logic transient_source_reg;
		logic orientation_status_reg;
		logic tap_source_reg;
		logic fall_motion_source_reg;
		logic x_msb;
		logic y_msb;
		logic z_msb;
	} msis_src_rd_t;

	// Mode and sample-rate controls from the configuration registers.
	typedef struct packed {
		logic       device_active;
		logic       auto_sleep_en;
		logic [7:0] sleep_idle_limit;
		logic [2:0] wake_rate;
		logic [2:0] sleep_rate;
	} msis_ctrl_t;

endpackage : msis_pkg

//--- msis_lvl_sync.sv
// Purpose: Two-stage synchroniser for independent level bits.
// Assumes: Each bit changes alone or is gray coded with its neighbours.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module msis_lvl_sync #(
	parameter int WIDTH = 10
) (
	input  wire logic             clk,    // Destination clock.
	input  wire logic             resetn, // Asynchronous reset, active low.
	input  wire logic [WIDTH-1:0] d,      // Levels from the other domain.
	output logic      [WIDTH-1:0] q       // Synchronised levels.
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} msis_lvl_st_t;

	msis_lvl_st_t st_r;
	msis_lvl_st_t st_nxt;

	// Shift each bit through two stages.
	always_comb begin
		st_nxt.meta = d;
		st_nxt.sync = st_r.meta;
	end

	// Both stages clear on reset.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.sync;
endmodule : msis_lvl_sync

//--- msis_evt_sync.sv
// Purpose: Turns toggles from another clock into one-cycle pulses.
// Assumes: Each toggle flips at most once per three destination cycles.
// Notes: The edge detector reads only the second and third stages.
`timescale 1ns/1ps
module msis_evt_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,    // Destination clock.
	input  wire logic             resetn, // Asynchronous reset, active low.
	input  wire logic [WIDTH-1:0] tgl,    // Toggles from the source domain.
	output logic      [WIDTH-1:0] pulse   // One pulse per toggle.
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] last;
	} msis_evt_st_t;

	msis_evt_st_t st_r;
	msis_evt_st_t st_nxt;

	// Three stages; the last one holds the previous synchronised level.
	always_comb begin
		st_nxt.meta = tgl;
		st_nxt.sync = st_r.meta;
		st_nxt.last = st_r.sync;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// A change between the settled stages marks one event per bit.
	genvar i;
	for (i = 0; i < WIDTH; i++) begin : g_edge
		assign pulse[i] = st_r.sync[i] ^ st_r.last[i];
	end
endmodule : msis_evt_sync

//--- msis_status.sv
// Purpose: Operating mode, interrupt source flags and identity readout.
// Assumes: Detection engines and configuration are on sys_clk; reads on link_clk.
// Notes: Register reads answer one link cycle after the read strobe.
`timescale 1ns/1ps
module msis_status
	import msis_pkg::*;
(
	input  wire logic                  sys_clk,           // System clock, 40 MHz.
	input  wire logic                  resetn,            // Asynchronous reset, active low.
	input  wire msis_pkg::msis_ctrl_t  ctrl,              // Mode and rate controls.
	input  wire msis_pkg::msis_func_t  event_active,      // Event-active bits of functions.
	input  wire msis_pkg::msis_func_t  func_int_en,       // Interrupt enables of functions.
	input  wire msis_pkg::msis_func_t  wake_sel,          // Functions that may wake.
	input  wire logic                  sample_ready_en,   // Sample-ready interrupt enable.
	input  wire logic                  idle_tick,         // Pulse per idle time unit.
	input  wire logic                  new_sample,        // Pulse when a new set is stored.
	input  wire logic [2:0]            axis_en,           // Enabled axes, Z Y X.
	input  wire logic                  link_clk,          // Register link clock.
	input  wire logic                  rd_stb,            // Read strobe of this block.
	input  wire logic [7:0]            rd_addr,           // Read address.
	input  wire msis_pkg::msis_src_rd_t src_rd,           // Reads of outside registers.
	output logic      [7:0]            rd_data,           // Read data, link domain.
	output logic      [1:0]            operating_mode_field, // Current mode.
	output logic      [7:0]            int_source,        // Source flags.
	output logic                       all_axis_ready_bit,   // New set ready.
	output logic                       all_axis_overrun_bit, // Set overwritten.
	output logic      [2:0]            output_sample_rate    // Selected sample rate.
);
	// System-domain state.
	typedef struct packed {
		msis_mode_t  mode;
		logic [1:0]  mode_gray;
		logic [7:0]  idle_cnt;
		logic [7:0]  flags;
		msis_func_t  cond_prev;
		logic        drdy_prev;
		logic [2:0]  axis_rdy;
		logic        all_rdy;
		logic        all_ovr;
		logic [2:0]  rate;
	} msis_sys_t;

	// Link-domain state.
	typedef struct packed {
		logic [7:0]             rdata;
		logic [MSIS_NUM_EV-1:0] ev_tgl;
	} msis_link_t;

	msis_sys_t  sys_r;
	msis_sys_t  sys_nxt;
	msis_link_t lnk_r;
	msis_link_t lnk_nxt;

	logic [MSIS_NUM_EV-1:0] rd_ev;
	logic [9:0]             lnk_sync;
	msis_func_t             cond;
	logic                   drdy_cond;

	// Gray code of a mode, so only one bit moves per step between neighbours.
	function automatic logic [1:0] msis_to_gray(input msis_mode_t m);
		unique case (m)
			MSIS_WAKE:  msis_to_gray = MSIS_GRAY_WAKE;
			MSIS_SLEEP: msis_to_gray = MSIS_GRAY_SLEEP;
			default:    msis_to_gray = MSIS_GRAY_STANDBY;
		endcase
	endfunction : msis_to_gray

	// Register encoding back from the gray code seen on the link side.
	function automatic logic [1:0] msis_from_gray(input logic [1:0] g);
		unique case (g)
			MSIS_GRAY_WAKE:  msis_from_gray = 2'(MSIS_WAKE);
			MSIS_GRAY_SLEEP: msis_from_gray = 2'(MSIS_SLEEP);
			default:         msis_from_gray = 2'(MSIS_STANDBY);
		endcase
	endfunction : msis_from_gray

	// Read events from the link arrive here as single sys_clk pulses.
	msis_evt_sync #(
		.WIDTH (MSIS_NUM_EV)
	) u_evt_sync (
		.clk    (sys_clk),
		.resetn (resetn),
		.tgl    (lnk_r.ev_tgl),
		.pulse  (rd_ev)
	);

	// Flags are independent bits and the mode is gray coded, so plain
	// two-stage synchronisers are enough for the link readout.
	msis_lvl_sync #(
		.WIDTH (10)
	) u_lvl_sync (
		.clk    (link_clk),
		.resetn (resetn),
		.d      ({sys_r.mode_gray, sys_r.flags}),
		.q      (lnk_sync)
	);

	always_comb begin
		cond = event_active & func_int_en;
		drdy_cond = (sys_r.all_rdy | sys_r.all_ovr) & sample_ready_en;
	end

	// System-domain next state.
	always_comb begin
		logic       wake_evt;
		logic       any_evt;
		logic       aslp_set;
		logic [2:0] rd_axes;
		logic       data_done;
		wake_evt  = 1'b0;
		any_evt   = 1'b0;
		aslp_set  = 1'b0;
		rd_axes   = '0;
		data_done = 1'b0;
		sys_nxt   = sys_r;

		sys_nxt.cond_prev = cond;
		sys_nxt.drdy_prev = drdy_cond;
		any_evt  = |(cond & ~sys_r.cond_prev);
		wake_evt = |(cond & ~sys_r.cond_prev & wake_sel);

		rd_axes = {rd_ev[MSIS_EV_Z], rd_ev[MSIS_EV_Y], rd_ev[MSIS_EV_X]};
		sys_nxt.axis_rdy = sys_r.axis_rdy & ~rd_axes;
		if ((sys_r.all_rdy || sys_r.all_ovr) && (|rd_axes)
				&& ((sys_nxt.axis_rdy & axis_en) == 3'h0)) begin
			data_done = 1'b1;
		end
		if (data_done) begin
			sys_nxt.all_rdy = 1'b0;
			sys_nxt.all_ovr = 1'b0;
		end
		// A new set wins over a read completing in the same cycle.
		if (new_sample) begin
			if (|(sys_nxt.axis_rdy & axis_en)) begin
				sys_nxt.all_ovr = 1'b1;
			end
			sys_nxt.axis_rdy = sys_nxt.axis_rdy | axis_en;
			sys_nxt.all_rdy  = 1'b1;
		end

		// Mode machine; standby whenever the device is not active.
		unique case (sys_r.mode)
			MSIS_STANDBY: begin
				sys_nxt.idle_cnt = MSIS_RST_IDLE;
				if (ctrl.device_active) begin
					sys_nxt.mode = MSIS_WAKE;
				end
			end
			MSIS_WAKE: begin
				if (!ctrl.device_active) begin
					sys_nxt.mode = MSIS_STANDBY;
				end else if (any_evt || !ctrl.auto_sleep_en) begin
					sys_nxt.idle_cnt = MSIS_RST_IDLE;
				end else if (idle_tick) begin
					if (sys_r.idle_cnt >= ctrl.sleep_idle_limit) begin
						sys_nxt.mode     = MSIS_SLEEP;
						sys_nxt.idle_cnt = MSIS_RST_IDLE;
						aslp_set         = 1'b1;
					end else begin
						sys_nxt.idle_cnt = sys_r.idle_cnt + 8'h01;
					end
				end
			end
			MSIS_SLEEP: begin
				if (!ctrl.device_active) begin
					sys_nxt.mode = MSIS_STANDBY;
				end else if (wake_evt || !ctrl.auto_sleep_en) begin
					sys_nxt.mode     = MSIS_WAKE;
					sys_nxt.idle_cnt = MSIS_RST_IDLE;
					aslp_set         = wake_evt;
				end
			end
			default: begin
				sys_nxt.mode = MSIS_STANDBY;
			end
		endcase
		sys_nxt.mode_gray = msis_to_gray(sys_nxt.mode);
		sys_nxt.rate = (sys_nxt.mode == MSIS_SLEEP) ? ctrl.sleep_rate : ctrl.wake_rate;

		// clears first, sets after, so a set in the clear cycle survives.
		if (rd_ev[MSIS_EV_MODE]) begin
			sys_nxt.flags[MSIS_BIT_ASLP] = 1'b0;
		end
		if (rd_ev[MSIS_EV_TRANS]) begin
			sys_nxt.flags[MSIS_BIT_TRANS] = 1'b0;
		end
		if (rd_ev[MSIS_EV_ORIEN]) begin
			sys_nxt.flags[MSIS_BIT_ORIEN] = 1'b0;
		end
		if (rd_ev[MSIS_EV_TAP]) begin
			sys_nxt.flags[MSIS_BIT_TAP] = 1'b0;
		end
		if (rd_ev[MSIS_EV_FALL]) begin
			sys_nxt.flags[MSIS_BIT_FALL] = 1'b0;
		end
		if (data_done) begin
			sys_nxt.flags[MSIS_BIT_DRDY] = 1'b0;
		end

		if (aslp_set) begin
			sys_nxt.flags[MSIS_BIT_ASLP] = 1'b1;
		end
		if (cond.transient && !sys_r.cond_prev.transient) begin
			sys_nxt.flags[MSIS_BIT_TRANS] = 1'b1;
		end
		if (cond.orientation && !sys_r.cond_prev.orientation) begin
			sys_nxt.flags[MSIS_BIT_ORIEN] = 1'b1;
		end
		if (cond.tap && !sys_r.cond_prev.tap) begin
			sys_nxt.flags[MSIS_BIT_TAP] = 1'b1;
		end
		if (cond.fall_motion && !sys_r.cond_prev.fall_motion) begin
			sys_nxt.flags[MSIS_BIT_FALL] = 1'b1;
		end
		if (drdy_cond && !sys_r.drdy_prev) begin
			sys_nxt.flags[MSIS_BIT_DRDY] = 1'b1;
		end
		sys_nxt.flags[6] = 1'b0;
		sys_nxt.flags[1] = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sys_r.mode      <= MSIS_STANDBY;
			sys_r.mode_gray <= MSIS_GRAY_STANDBY;
			sys_r.idle_cnt  <= MSIS_RST_IDLE;
			sys_r.flags     <= MSIS_RST_INT_SOURCE;
			sys_r.cond_prev <= '0;
			sys_r.drdy_prev <= 1'b0;
			sys_r.axis_rdy  <= '0;
			sys_r.all_rdy   <= 1'b0;
			sys_r.all_ovr   <= 1'b0;
			sys_r.rate      <= '0;
		end else begin
			sys_r <= sys_nxt;
		end
	end

	// Link-domain read answers and read-event toggles.
	always_comb begin
		lnk_nxt = lnk_r;
		if (rd_stb) begin
			unique case (rd_addr)
				MSIS_ADDR_SYSTEM_MODE: begin
					lnk_nxt.rdata = {MSIS_RST_SYSTEM_MODE[7:2], msis_from_gray(lnk_sync[9:8])};
				end
				MSIS_ADDR_INT_SOURCE: begin
					lnk_nxt.rdata = lnk_sync[7:0];
				end
				MSIS_ADDR_PART_ID: begin
					lnk_nxt.rdata = MSIS_PART_ID_VALUE;
				end
				default: begin
					lnk_nxt.rdata = 8'h00;
				end
			endcase
		end
		if (rd_stb && (rd_addr == MSIS_ADDR_SYSTEM_MODE)) begin
			lnk_nxt.ev_tgl[MSIS_EV_MODE] = ~lnk_r.ev_tgl[MSIS_EV_MODE];
		end
		if (src_rd.transient_source_reg) begin
			lnk_nxt.ev_tgl[MSIS_EV_TRANS] = ~lnk_r.ev_tgl[MSIS_EV_TRANS];
		end
		if (src_rd.orientation_status_reg) begin
			lnk_nxt.ev_tgl[MSIS_EV_ORIEN] = ~lnk_r.ev_tgl[MSIS_EV_ORIEN];
		end
		if (src_rd.tap_source_reg) begin
			lnk_nxt.ev_tgl[MSIS_EV_TAP] = ~lnk_r.ev_tgl[MSIS_EV_TAP];
		end
		if (src_rd.fall_motion_source_reg) begin
			lnk_nxt.ev_tgl[MSIS_EV_FALL] = ~lnk_r.ev_tgl[MSIS_EV_FALL];
		end
		if (src_rd.x_msb) begin
			lnk_nxt.ev_tgl[MSIS_EV_X] = ~lnk_r.ev_tgl[MSIS_EV_X];
		end
		if (src_rd.y_msb) begin
			lnk_nxt.ev_tgl[MSIS_EV_Y] = ~lnk_r.ev_tgl[MSIS_EV_Y];
		end
		if (src_rd.z_msb) begin
			lnk_nxt.ev_tgl[MSIS_EV_Z] = ~lnk_r.ev_tgl[MSIS_EV_Z];
		end
	end

	// The link clock may stop between frames; toggles keep their level.
	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			lnk_r <= '0;
		end else begin
			lnk_r <= lnk_nxt;
		end
	end

	// Outputs straight from flip-flops.
	assign rd_data              = lnk_r.rdata;
	assign operating_mode_field = sys_r.mode;
	assign int_source           = sys_r.flags;
	assign all_axis_ready_bit   = sys_r.all_rdy;
	assign all_axis_overrun_bit = sys_r.all_ovr;
	assign output_sample_rate   = sys_r.rate;
endmodule : msis_status

//--- msis_status_checker.sv
// Purpose: Port checks on mode and source flags of the status block.
// Assumes: Every watched port lives in the sys_clk domain.
// Notes: Link reads are judged by the bench, not here.
`timescale 1ns/1ps
module msis_status_checker
	import msis_pkg::*;
(
	input wire logic                 sys_clk,              // System clock.
	input wire logic                 resetn,               // Reset, active low.
	input wire msis_pkg::msis_ctrl_t ctrl,                 // Mode controls.
	input wire msis_pkg::msis_func_t event_active,         // Event bits.
	input wire msis_pkg::msis_func_t func_int_en,          // Enables.
	input wire msis_pkg::msis_func_t wake_sel,             // Wake sources.
	input wire logic                 idle_tick,            // Idle pulse.
	input wire logic                 new_sample,           // New set pulse.
	input wire logic [1:0]           operating_mode_field, // Mode.
	input wire logic [7:0]           int_source,           // Flags.
	input wire logic                 all_axis_ready_bit,   // Ready.
	input wire logic                 all_axis_overrun_bit, // Overrun.
	input wire logic [2:0]           output_sample_rate    // Rate.
);
	msis_func_t prev_r;
	msis_func_t rise;
	// A rise needs the enabled event low one cycle before, as the flags do.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prev_r <= '0;
		end else begin
			prev_r <= event_active & func_int_en;
		end
	end
	assign rise = event_active & func_int_en & ~prev_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Mode steps between wake and sleep.
	sequence s_to_sleep;
		operating_mode_field == 2'h1 ##1 operating_mode_field == 2'h2;
	endsequence
	sequence s_to_wake;
		operating_mode_field == 2'h2 ##1 operating_mode_field == 2'h1;
	endsequence
	// A selected wake source rises while asleep with auto-sleep allowed.
	sequence s_wake_cause;
		operating_mode_field == 2'h2 && ctrl.device_active && ctrl.auto_sleep_en
			&& (rise & wake_sel) != '0;
	endsequence
	mode_legal_a: assert property (operating_mode_field != 2'h3)
		else $error("mode code 3 seen");
	src_zero_a: assert property (int_source[6] == 1'b0 && int_source[1] == 1'b0)
		else $error("reserved source bit set");
	flag_set_a: assert property (
		rise != '0 |=> (int_source[5:2] & $past(rise)) == $past(rise))
		else $error("rising event left its flag clear");
	// reset values; the first edge is skipped since the flops may not have seen reset yet.
	reset_zero_a: assert property (disable iff (1'b0)
		!resetn && !$past(resetn) |-> int_source == 8'h00 && operating_mode_field == 2'h0)
		else $error("flags or mode nonzero in reset");
	sleep_step_a: assert property (s_to_sleep |-> $past(idle_tick) && int_source[7])
		else $error("sleep entered without tick or flag");
	wake_step_a: assert property (s_to_wake |-> int_source[7] || !$past(ctrl.auto_sleep_en))
		else $error("wake entered without flag");
	wake_event_a: assert property (s_wake_cause |=> operating_mode_field == 2'h1)
		else $error("selected event did not wake");
	standby_a: assert property (!ctrl.device_active |=> operating_mode_field == 2'h0)
		else $error("mode not standby while inactive");
	// rate selection; the rate is registered with the new mode, from last cycle's controls.
	rate_sel_a: assert property (
		$past(resetn) |-> output_sample_rate == ((operating_mode_field == 2'h2) ?
			$past(ctrl.sleep_rate) : $past(ctrl.wake_rate)))
		else $error("sample rate does not follow mode");
	ready_set_a: assert property (new_sample |=> all_axis_ready_bit)
		else $error("ready not set by new sample");
	// sample flag cause, judged on the cycle the flag was set.
	drdy_cause_a: assert property (
		$rose(int_source[0]) |-> $past(all_axis_ready_bit || all_axis_overrun_bit))
		else $error("sample flag without ready or overrun");
endmodule : msis_status_checker

bind msis_status msis_status_checker i_chk (
	.sys_clk(sys_clk),
	.resetn(resetn),
	.ctrl(ctrl),
	.event_active(event_active),
	.func_int_en(func_int_en),
	.wake_sel(wake_sel),
	.idle_tick(idle_tick),
	.new_sample(new_sample),
	.operating_mode_field(operating_mode_field),
	.int_source(int_source),
	.all_axis_ready_bit(all_axis_ready_bit),
	.all_axis_overrun_bit(all_axis_overrun_bit),
	.output_sample_rate(output_sample_rate)
);

//--- msis_host.sv
// Purpose: Host on the register link: reads and outside source reads.
// Assumes: One request per link edge, taken on the rising edge.
// Notes: A released address shows its inverse, never the old value.
`timescale 1ns/1ps
module msis_host
	import msis_pkg::*;
(
	input  wire logic             link_clk, // Link clock.
	input  wire logic [7:0]       rd_data,  // Answer, judged by the bench.
	output logic                  rd_stb,   // Read strobe.
	output logic [7:0]            rd_addr,  // Read address.
	output msis_pkg::msis_src_rd_t src_rd   // Outside register reads.
);
	initial begin
		rd_stb = 1'b0;
		rd_addr = 8'h00;
		src_rd = '0;
	end
	// register reads at any address.
	// The strobe stands for exactly one edge; the answer follows that edge.
	task automatic rd(input logic [7:0] a);
		@(posedge link_clk);
		#1;
		rd_stb = 1'b1;
		rd_addr = a;
		@(posedge link_clk);
		#1;
		rd_stb = 1'b0;
		rd_addr = ~a;
		@(posedge link_clk);
	endtask : rd
	// Idle edges after each pulse keep clears of one register apart.
	task automatic clr(input int i);
		@(posedge link_clk);
		#1;
		src_rd = msis_src_rd_t'(7'h01 << i);
		@(posedge link_clk);
		#1;
		src_rd = '0;
		@(posedge link_clk);
		@(posedge link_clk);
	endtask : clr
endmodule : msis_host

//--- tb.sv
// Purpose: Self-checking bench for the status block.
// Assumes: The host model makes all link requests.
// Notes: Expected answers queue up and meet each read as it lands.
`timescale 1ns/1ps
module tb;
	import msis_pkg::*;
	logic         sys_clk, link_clk, resetn, tick, nsmp, sre, rd_stb, rdy, ovr;
	msis_ctrl_t   ctrl;
	msis_func_t   ev, en, ws;
	msis_src_rd_t src_rd;
	logic [7:0]   rd_addr, rd_data, isrc;
	logic [2:0]   axen, rate;
	logic [1:0]   mode;
	logic [7:0]   expq[$];
	int           failures, cmp_count, lim;
	msis_status i_msis_status (.sys_clk(sys_clk), .resetn(resetn), .ctrl(ctrl),
		.event_active(ev), .func_int_en(en), .wake_sel(ws), .sample_ready_en(sre),
		.idle_tick(tick), .new_sample(nsmp), .axis_en(axen), .link_clk(link_clk),
		.rd_stb(rd_stb), .rd_addr(rd_addr), .src_rd(src_rd), .rd_data(rd_data),
		.operating_mode_field(mode), .int_source(isrc), .all_axis_ready_bit(rdy),
		.all_axis_overrun_bit(ovr), .output_sample_rate(rate));
	msis_host i_msis_host (.link_clk(link_clk), .rd_data(rd_data), .rd_stb(rd_stb),
		.rd_addr(rd_addr), .src_rd(src_rd));
	// System clock at 40 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Link clock at 32 ns, offset so the two never line up.
	initial begin
		link_clk = 1'b0;
		#7.3;
		forever #16 link_clk = ~link_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Each answer is matched with the oldest noted value.
	always @(posedge link_clk) begin
		if (rd_stb === 1'b1) begin
			#1;
			chk(rd_data, (expq.size() > 0) ? expq.pop_front() : 8'hxx);
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	// The wait lets flags cross to the link before the read.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		cyc(12);
		expq.push_back(e);
		i_msis_host.rd(a);
		// Resume just after a system edge, so later stimulus never lands near one.
		cyc(1);
	endtask : rd
	task automatic pl(input bit smp, input int n);
		repeat (n) begin
			cyc(2);
			if (smp) nsmp = 1'b1;
			else tick = 1'b1;
			cyc(1);
			nsmp = 1'b0;
			tick = 1'b0;
		end
	endtask : pl
	task automatic conclude();
		if (expq.size() != 0) failures++;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	// A hang is cut short and counted.
	initial begin
		#1000000;
		failures++;
		conclude();
	end
	initial begin
		void'($urandom(87068));
		{resetn, tick, nsmp, sre, axen, ev, en, failures, cmp_count} = '0;
		lim = $urandom_range(4, 1);
		ctrl = '0;
		ctrl.sleep_idle_limit = lim[7:0];
		ctrl.wake_rate = 3'($urandom);
		ctrl.sleep_rate = ~ctrl.wake_rate;
		ws = msis_func_t'(4'($urandom) | 4'h2);
		cyc(3);
		resetn = 1'b1;
		rd(8'h0b, 8'h00);
		rd(8'h0c, 8'h00);
		rd(8'h0d, MSIS_PART_ID_VALUE);
		rd(8'h0e, 8'h00);
		ctrl.device_active = 1'b1;
		ctrl.auto_sleep_en = 1'b1;
		en = 4'hf;
		rd(8'h0b, 8'h01);
		// Each flag outlives its event and survives two interrupt source reads, then clears on its own source read.
		for (int i = 0; i < 4; i++) begin
			ev = msis_func_t'(4'h1 << i);
			cyc(2);
			ev = '0;
			rd(8'h0c, 8'h04 << i);
			rd(8'h0c, 8'h04 << i);
			i_msis_host.clr(i + 3);
			rd(8'h0c, 8'h00);
		end
		// Only events whose enables are off rise here, so nothing may latch.
		en = 4'($urandom_range(14, 1));
		ev = ~en;
		cyc(2);
		ev = '0;
		rd(8'h0c, 8'h00);
		en = 4'hf;
		pl(0, lim);
		rd(8'h0b, 8'h01);
		pl(0, 1);
		rd(8'h0c, 8'h80);
		rd(8'h0b, 8'h02);
		chk({5'h0, rate}, {5'h0, ctrl.sleep_rate});
		rd(8'h0c, 8'h00);
		ev = 4'h2;
		cyc(2);
		ev = '0;
		rd(8'h0c, 8'h88);
		rd(8'h0b, 8'h01);
		chk({5'h0, rate}, {5'h0, ctrl.wake_rate});
		i_msis_host.clr(4);
		rd(8'h0c, 8'h00);
		axen = 3'h7;
		pl(1, 1);
		rd(8'h0c, 8'h00);
		chk({7'h0, rdy}, 8'h01);
		sre = 1'b1;
		rd(8'h0c, 8'h01);
		rd(8'h00, 8'h00);
		rd(8'h0c, 8'h01);
		i_msis_host.clr(2);
		i_msis_host.clr(1);
		pl(1, 1);
		cyc(2);
		chk({7'h0, ovr}, 8'h01);
		i_msis_host.clr(2);
		i_msis_host.clr(1);
		rd(8'h0c, 8'h01);
		i_msis_host.clr(0);
		rd(8'h0c, 8'h00);
		chk({6'h0, rdy, ovr}, 8'h00);
		axen = 3'h1;
		pl(1, 1);
		i_msis_host.clr(2);
		rd(8'h0c, 8'h00);
		ctrl.device_active = 1'b0;
		rd(8'h0b, 8'h00);
		conclude();
	end
endmodule : tb
